// ===== dv/acl_channel_asserts.sv
// Purpose: port-level checks for the link audio channel
// Assumes: one ref_clk domain, async active-high reset
// Notes:   sync length allows a cycle of bit clock sampling jitter
`timescale 1ns/1ns
module acl_channel_asserts
  import acl_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // control
  input wire logic              codecResetCtl,
  input wire logic [CTRL_W-1:0] txChannelControl,
  input wire logic [CTRL_W-1:0] rxChannelControl,
  input wire logic              cmdAddrWrite,
  input wire logic              cmdDataWrite,
  // status and pins
  input wire logic [1:0]        slotBusy,
  input wire logic              txFull,
  input wire logic              rxEmpty,
  input wire logic              syncOut,
  input wire logic              codecResetN
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_reset_pin: assert property (codecResetN == !codecResetCtl)
    else $error("reset pin");
  a_busy_data: assert property (cmdDataWrite |=> slotBusy[1])
    else $error("slot2 busy");
  a_busy_addr: assert property (cmdAddrWrite |=> slotBusy[0])
    else $error("slot1 busy");
  a_busy_clear: assert property ($fell(slotBusy[0]) |-> $past(syncOut) && !$past(syncOut, 2))
    else $error("busy clear");
  a_busy_pair: assert property ($fell(slotBusy[1]) |-> $fell(slotBusy[0]))
    else $error("busy pair");
  a_sync_len: assert property ($fell(syncOut) |-> $past(syncOut, 120) && !$past(syncOut, 136))
    else $error("sync length");
  a_frame_low: assert property ($rose(syncOut) |-> !$past(syncOut, 200))
    else $error("frame gap");
  a_full_hold: assert property (txFull && !txChannelControl[0] |=> txFull)
    else $error("tx full");
  a_empty_hold: assert property (rxEmpty && !rxChannelControl[0] && !$past(rxChannelControl[0])
    |=> rxEmpty)
    else $error("rx empty");
  c_both_busy: cover property (slotBusy == 2'h3);
  c_tx_full: cover property ($rose(txFull));
  c_rx_data: cover property ($fell(rxEmpty));
endmodule
bind acl_channel acl_channel_asserts chk (.ref_clk, .reset, .codecResetCtl, .txChannelControl,
  .rxChannelControl, .cmdAddrWrite, .cmdDataWrite, .slotBusy, .txFull, .rxEmpty, .syncOut,
  .codecResetN);

// ===== dv/acl_codec_model.sv
// Purpose: behavioural codec on the far side of the link
// Assumes: bit clock runs free at a 160 ns period
// Notes:   frame phase locks on the sync rise seen at a falling edge
`timescale 1ns/1ns
module acl_codec_model (
  // link pins
  output logic      bitClk,
  output logic      serialIn,
  input  wire logic codecResetN,
  input  wire logic syncOut,
  input  wire logic serialOut
);
  // both record slots carry one value so channel order cannot matter
  localparam logic [19:0]  REC = 20'h5678c;
  localparam logic [255:0] RX_FRAME = {16'h9800, 40'h0, REC, REC, 160'h0};
  int           cnt = 0;
  int           frames = 0;
  int           hiCnt = 0;
  int           hiLen = 0;
  int           gap = 0;
  int           frameLen = 0;
  logic         syncPrev = 1'b0;
  logic [255:0] txSh = '0;
  logic [19:0]  lastS1, lastS2;
  logic [19:0]  s3q[$];
  logic [19:0]  s4q[$];
  logic         muted = 1'b0;
  int           rateHz = 0;
  // controls come back muted and the rate fixed at 48000 Hz whenever reset is driven
  always @(negedge codecResetN) begin
    muted = 1'b1;
    rateHz = 48000;
  end
  initial bitClk = 1'b0;
  initial serialIn = 1'b0;
  always #80 bitClk = ~bitClk;
  // tag bit 15 goes out on the rise after the one that raised sync
  always @(posedge bitClk) serialIn <= RX_FRAME[255 - cnt];
  always @(negedge bitClk) begin
    gap++;
    if (syncOut && !syncPrev) begin
      frameLen = gap;
      gap = 0;
      cnt = 0;
    end else begin
      cnt = (cnt + 1) % 256;
    end
    if (syncPrev && !syncOut) hiLen = hiCnt;
    hiCnt = syncOut ? hiCnt + 1 : 0;
    syncPrev = syncOut;
    txSh = {txSh[254:0], serialOut};
    // txSh[0] holds frame bit 254 here; frames count only once locked to sync
    if (cnt == 255 && frameLen != 0) begin
      frames++;
      if (txSh[253]) lastS1 = txSh[238:219];
      if (txSh[252]) lastS2 = txSh[218:199];
      if (txSh[251]) s3q.push_back(txSh[198:179]);
      if (txSh[250]) s4q.push_back(txSh[178:159]);
    end
  end
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for the link audio channel
// Assumes: codec model makes the bit clock and record data
// Notes:   expected fields rebuilt from the shift of each width code
`timescale 1ns/1ns
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  import acl_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic              codecResetCtl = 1'b0;
  logic [2:0]        mainControl = 3'h0;
  logic [CTRL_W-1:0] txChannelControl = 5'h00;
  logic [CTRL_W-1:0] rxChannelControl = 5'h00;
  logic [19:0]       cmdAddrData = 20'h0, cmdDataData = 20'h0;
  logic              cmdAddrWrite = 1'b0, cmdDataWrite = 1'b0;
  logic [31:0]       txWordData = 32'h0, rxWordData, rd;
  logic              txWordWrite = 1'b0, rxWordRead = 1'b0;
  logic [1:0]        slotBusy;
  logic              txFull, rxEmpty, bitClk, serialIn, syncOut, serialOut, codecResetN;
  int                mismatches = 0, nCompared = 0, cycles = 0, sh;
  acl_channel dut (.ref_clk, .reset, .codecResetCtl, .mainControl, .txChannelControl,
    .rxChannelControl, .cmdAddrData, .cmdAddrWrite, .cmdDataData, .cmdDataWrite, .slotBusy,
    .txWordData, .txWordWrite, .rxWordData, .rxWordRead, .txFull, .rxEmpty, .bitClk,
    .serialIn, .syncOut, .serialOut, .codecResetN);
  acl_codec_model codec (.bitClk, .serialIn, .codecResetN, .syncOut, .serialOut);
  always #10 ref_clk = ~ref_clk;
  task automatic stop_test();
    if (mismatches == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // about 25 frames of 2048 cycles are needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic waitFrames(int n);
    int f;
    f = codec.frames;
    wait (codec.frames >= f + n);
    // return just past the next frame start so fills never straddle one
    repeat (20) @(negedge ref_clk);
  endtask
  task automatic wrWord(logic [31:0] d);
    txWordData = d;
    txWordWrite = 1'b1;
    @(negedge ref_clk);
    txWordWrite = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rdWord(output logic [31:0] d);
    d = rxWordData;
    rxWordRead = 1'b1;
    @(negedge ref_clk);
    rxWordRead = 1'b0;
    @(negedge ref_clk);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    `CHK({rxEmpty, txFull, slotBusy}, 4'h8)
    reset = 1'b0;
    codecResetCtl = 1'b1; // short pulse: the model needs no settling time
    @(negedge ref_clk);
    `CHK(codecResetN, 1'b0)
    `CHK(codec.muted, 1'b1)
    `CHK(codec.rateHz, 48000)
    codecResetCtl = 1'b0;
    @(negedge ref_clk);
    `CHK(codecResetN, 1'b1)
    mainControl = 3'h7;
    txChannelControl = 5'h07;
    cmdDataData = 20'h0a5c3;
    cmdDataWrite = 1'b1;
    @(negedge ref_clk);
    cmdDataWrite = 1'b0;
    `CHK(slotBusy, 2'h2)
    cmdAddrData = 20'h2c000;
    cmdAddrWrite = 1'b1;
    @(negedge ref_clk);
    cmdAddrWrite = 1'b0;
    `CHK(slotBusy, 2'h3)
    waitFrames(2);
    `CHK(slotBusy, 2'h0)
    `CHK({codec.lastS1, codec.lastS2}, {20'h2c000, 20'h0a5c3})
    `CHK(codec.hiLen, 16)
    `CHK(codec.frameLen, 256)
    for (int i = 0; i < 9; i++) wrWord(i[0] ? 32'h3c7 : 32'ha5c);
    `CHK(txFull, 1'b1)
    txChannelControl = 5'h00;
    waitFrames(1);
    `CHK(txFull, 1'b1)
    txChannelControl = 5'h07;
    waitFrames(6);
    `CHK(codec.s3q.size(), 4)
    for (int w = 0; w < 4; w++) begin
      sh = (w == 0) ? 4 : (w == 1) ? 2 : (w == 2) ? 0 : 8;
      rxChannelControl = 5'h00;
      while (rxEmpty !== 1'b1) rdWord(rd);
      txChannelControl = {w[1:0], 3'h7};
      // rx width bits set to the 12-bit code and must be ignored
      rxChannelControl = 5'h1f;
      codec.s3q.delete();
      codec.s4q.delete();
      wrWord(32'ha5c);
      wrWord(32'h3c7);
      waitFrames(3);
      rdWord(rd);
      `CHK(rd, 32'(20'h5678c >> sh))
      `CHK(codec.s3q[0], 20'(32'ha5c << sh))
      `CHK(codec.s4q[0], 20'(32'h3c7 << sh))
    end
    txChannelControl = 5'h03;
    codec.s3q.delete();
    codec.s4q.delete();
    wrWord(32'ha5c);
    wrWord(32'h3c7);
    waitFrames(3);
    `CHK(codec.s3q.size(), 2)
    `CHK(codec.s3q[1], 20'h3c70)
    `CHK(codec.s4q.size(), 0)
    stop_test();
  end
endmodule

// ===== logic/acl_channel.sv
// Purpose: one audio channel on the five-wire link: command slots, fifo-paced play and record
// Assumes: bit clock comes from the codec and is sampled by ref_clk (>= 3x faster)
// Notes:   control bits are plain ports; sync and data out change on bit clock rising edge,
//          data in is taken on the falling edge
`timescale 1ns/1ns
// Functional notes
// - codecResetN pin is the inverse of bit 0 of codec reset control, directly.
// - rx control assigns receive fifo to slots 3 and 4, with enable.
// - tx control assigns transmit fifo to audio slots, with enable.
// - main control enables slots 1, 2 and the whole controller.
// - samples written only while tx full clear; sent one per frame slot.
// - received samples pushed to rx fifo; read only while not empty.
// - bus sample widths 12, 16, 18, 20 selectable; 16 after reset.
// - received 20-bit field right-shifted to lsb-justified selected width.
// - the width select field lives in tx channel control.
// - transmit sample left-shifted into 20 bits, low bits zero.
// - with only slot 3 enabled each word maps to slot 3 per frame.
// - each 32-bit data word carries exactly one sample.
// - 256-bit frames of 13 slots on codec bit clock; sync marks start.
module acl_channel
  import acl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // control ports
  input  wire logic              codecResetCtl,
  input  wire logic [2:0]        mainControl,
  input  wire logic [CTRL_W-1:0] txChannelControl,
  input  wire logic [CTRL_W-1:0] rxChannelControl,
  // command slot write ports
  input  wire logic [19:0]       cmdAddrData,
  input  wire logic              cmdAddrWrite,
  input  wire logic [19:0]       cmdDataData,
  input  wire logic              cmdDataWrite,
  output logic [1:0]             slotBusy,
  // channel data port
  input  wire logic [31:0]       txWordData,
  input  wire logic              txWordWrite,
  output logic [31:0]            rxWordData,
  input  wire logic              rxWordRead,
  output logic                   txFull,
  output logic                   rxEmpty,
  // link pins
  input  wire logic              bitClk,
  input  wire logic              serialIn,
  output logic                   syncOut,
  output logic                   serialOut,
  output logic                   codecResetN
);
  localparam int AW = $clog2(DEPTH);

  // two-stage synchronisers for link inputs
  logic [1:0] bclkSync_r, sdinSync_r;
  logic       bclkDly_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bclkSync_r <= 2'h0;
      sdinSync_r <= 2'h0;
      bclkDly_r  <= 1'b0;
    end else begin
      bclkSync_r <= {bclkSync_r[0], bitClk};
      sdinSync_r <= {sdinSync_r[0], serialIn};
      bclkDly_r  <= bclkSync_r[1];
    end
  end
  wire bclkRise = bclkSync_r[1] & ~bclkDly_r;
  wire bclkFall = ~bclkSync_r[1] & bclkDly_r;
  wire sdinBit  = sdinSync_r[1];

  assign codecResetN = ~codecResetCtl;

  wire linkOn  = mainControl[MAIN_EN_BIT];
  wire txEn    = txChannelControl[CH_EN_BIT];
  wire rxEn    = rxChannelControl[CH_EN_BIT];
  wire [1:0] widthSel = txChannelControl[CH_SIZE_LSB +: 2];

  // bit position in frame: tag slot 16 bits, then 12 slots of 20
  logic [7:0] bitCnt_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) bitCnt_r <= 8'h00;
    else if (!linkOn) bitCnt_r <= 8'h00;
    else if (bclkRise) bitCnt_r <= bitCnt_r + 8'h01;
  end
  wire frameStart = bclkRise && bitCnt_r == 8'(FRAME_BITS - 1);
  wire [7:0] slotBit = bitCnt_r - 8'(TAG_BITS);
  function automatic logic [3:0] slotOf(input logic [7:0] b);
    if (b < 8'(TAG_BITS)) slotOf = 4'h0;
    else slotOf = 4'(((b - 8'(TAG_BITS)) / 8'(SLOT_BITS)) + 8'h01);
  endfunction
  wire [3:0] curSlot = slotOf(bitCnt_r);
  wire [4:0] inSlot  = 5'((slotBit) % 8'(SLOT_BITS));

  // mono when slot 3 alone is enabled
  wire txMono = txChannelControl[CH_SL3_BIT] & ~txChannelControl[CH_SL4_BIT];
  wire rxMono = rxChannelControl[CH_SL3_BIT] & ~rxChannelControl[CH_SL4_BIT];

  // width conversion
  function automatic logic [19:0] toLink(input logic [31:0] s, input logic [1:0] w);
    unique case (w)
      SIZE_12: toLink = {s[11:0], 8'h00};
      SIZE_16: toLink = {s[15:0], 4'h0};
      SIZE_18: toLink = {s[17:0], 2'h0};
      SIZE_20: toLink = s[19:0];
    endcase
  endfunction
  function automatic logic [31:0] fromLink(input logic [19:0] f, input logic [1:0] w);
    unique case (w)
      SIZE_12: fromLink = {20'h00000, f[19:8]};
      SIZE_16: fromLink = {16'h0000, f[19:4]};
      SIZE_18: fromLink = {14'h0000, f[19:2]};
      SIZE_20: fromLink = {12'h000, f};
    endcase
  endfunction

  // fifos hold one sample per 32-bit word
  logic [31:0]   txMem [DEPTH];
  logic [31:0]   rxMem [DEPTH];
  logic [AW:0]   txWp_r, txRp_r, rxWp_r, rxRp_r;
  assign txFull  = (txWp_r - txRp_r) == (AW+1)'(DEPTH);
  assign rxEmpty = rxWp_r == rxRp_r;
  wire txEmpty = txWp_r == txRp_r;
  wire rxFull  = (rxWp_r - rxRp_r) == (AW+1)'(DEPTH);
  assign rxWordData = rxMem[rxRp_r[AW-1:0]];

  // slot loading: at frame start latch per-slot valid and fields
  logic [19:0] cmdAddr_r, cmdData_r, out3_r, out4_r;
  logic [4:0]  tag_r; // bit4 valid frame, 3 slot1, 2 slot2, 1 slot3, 0 slot4
  logic        cmdSent_r;
  wire txSl3 = txEn & txChannelControl[CH_SL3_BIT];
  wire txSl4 = txEn & txChannelControl[CH_SL4_BIT] & ~txMono;
  wire [AW:0] txCount = txWp_r - txRp_r;
  wire stereoOk = txCount >= (AW+1)'(2);
  wire take3 = txSl3 && (txSl4 ? stereoOk : !txEmpty);
  wire take4 = txSl4 && (txSl3 ? stereoOk : !txEmpty);
  wire sendCmd = slotBusy[0] & slotBusy[1] & mainControl[MAIN_S1_BIT]
                 & mainControl[MAIN_S2_BIT];
  wire [AW:0] txPop = (AW+1)'(take3) + (AW+1)'(take4);
  wire [31:0] txHead = txMem[txRp_r[AW-1:0]];
  wire [31:0] txNext = txMem[AW'(txRp_r[AW-1:0] + AW'(1))];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txWp_r <= '0;
      txRp_r <= '0;
      tag_r  <= 5'h00;
      out3_r <= 20'h00000;
      out4_r <= 20'h00000;
    end else begin
      if (txWordWrite && !txFull) txWp_r <= txWp_r + (AW+1)'(1);
      if (frameStart && linkOn) begin
        tag_r  <= {1'b1, sendCmd, sendCmd, take3, take4};
        out3_r <= take3 ? toLink(txHead, widthSel) : 20'h00000;
        out4_r <= take4 ? toLink(take3 ? txNext : txHead, widthSel) : 20'h00000;
        txRp_r <= txRp_r + txPop;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (txWordWrite && !txFull) txMem[txWp_r[AW-1:0]] <= txWordData;
  end

  // command slot registers and busy flags; a new write wins over the clear
  logic [1:0] busy_r;
  assign slotBusy = busy_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_r    <= 2'h0;
      cmdAddr_r <= 20'h00000;
      cmdData_r <= 20'h00000;
      cmdSent_r <= 1'b0;
    end else begin
      cmdSent_r <= frameStart && linkOn && sendCmd;
      if (cmdSent_r) busy_r <= 2'h0;
      if (cmdAddrWrite) begin
        cmdAddr_r <= cmdAddrData;
        busy_r[0] <= 1'b1;
      end
      if (cmdDataWrite) begin
        cmdData_r <= cmdDataData;
        busy_r[1] <= 1'b1;
      end
    end
  end

  // outgoing serial stream, msb first in every slot
  logic [19:0] field;
  always_comb begin
    unique case (curSlot)
      4'h1:    field = tag_r[3] ? cmdAddr_r : 20'h00000;
      4'h2:    field = tag_r[2] ? cmdData_r : 20'h00000;
      4'h3:    field = out3_r;
      4'h4:    field = out4_r;
      default: field = 20'h00000;
    endcase
  end
  wire [15:0] tagWord = {tag_r, 11'h000};
  wire txBit = (curSlot == 4'h0) ? tagWord[4'(15 - bitCnt_r[3:0])]
                                 : field[5'(19 - inSlot)];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      syncOut   <= 1'b0;
      serialOut <= 1'b0;
    end else if (bclkRise && linkOn) begin
      // sync high across the tag slot, first edge of frame
      syncOut   <= (bitCnt_r == 8'(FRAME_BITS - 1)) || (bitCnt_r < 8'(TAG_BITS - 1));
      serialOut <= txBit;
    end else if (!linkOn) begin
      syncOut   <= 1'b0;
      serialOut <= 1'b0;
    end
  end

  // receive: shift falling-edge samples; bit index lags one rise behind
  logic [19:0] rxShift_r;
  logic [4:0]  rxTag_r;
  wire [7:0] rxPos  = bitCnt_r - 8'h01;
  wire [3:0] rxSlot = slotOf(rxPos);
  wire [4:0] rxIn   = 5'((rxPos - 8'(TAG_BITS)) % 8'(SLOT_BITS));
  wire rxEndSlot = bclkFall && rxSlot != 4'h0 && rxIn == 5'(SLOT_BITS - 1);
  wire [19:0] rxField = {rxShift_r[18:0], sdinBit};
  wire rxWant = rxEn && ((rxSlot == 4'h3 && rxChannelControl[CH_SL3_BIT] && rxTag_r[1])
                || (rxSlot == 4'h4 && rxChannelControl[CH_SL4_BIT] && !rxMono && rxTag_r[0]));
  wire rxPush = rxEndSlot && rxWant && !rxFull;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxShift_r <= 20'h00000;
      rxTag_r   <= 5'h00;
      rxWp_r    <= '0;
      rxRp_r    <= '0;
    end else begin
      if (bclkFall) rxShift_r <= rxField;
      // the fifth tag bit has arrived: valid, slot 1..4 flags sit in the low five bits
      if (bclkFall && rxSlot == 4'h0 && rxPos[3:0] == 4'h4) rxTag_r <= rxField[4:0];
      if (rxPush) rxWp_r <= rxWp_r + (AW+1)'(1);
      if (rxWordRead && !rxEmpty) rxRp_r <= rxRp_r + (AW+1)'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rxPush) rxMem[rxWp_r[AW-1:0]] <= fromLink(rxField, widthSel);
  end
endmodule

// ===== logic/acl_pkg.sv
// Purpose: shared constants for the link audio channel controller
// Assumes: 50 MHz ref_clk, codec-driven bit clock
// Notes:   field positions of the control words held here
package acl_pkg;
  localparam int FRAME_BITS   = 256;
  localparam int SLOT_COUNT   = 13;
  localparam int TAG_BITS     = 16;
  localparam int SLOT_BITS    = 20;
  localparam int FIFO_DEPTH   = 8;
  // main control fields
  localparam int MAIN_EN_BIT  = 0;
  localparam int MAIN_S1_BIT  = 1;
  localparam int MAIN_S2_BIT  = 2;
  // tx/rx channel control fields
  localparam int CH_EN_BIT    = 0;
  localparam int CH_SL3_BIT   = 1;
  localparam int CH_SL4_BIT   = 2;
  localparam int CH_SIZE_LSB  = 3;
  localparam int CTRL_W       = 5;
  // sample width codes; 16 bits after reset
  localparam logic [1:0] SIZE_16 = 2'h0;
  localparam logic [1:0] SIZE_18 = 2'h1;
  localparam logic [1:0] SIZE_20 = 2'h2;
  localparam logic [1:0] SIZE_12 = 2'h3;
  localparam logic [CTRL_W-1:0] CH_CTRL_RESET = 5'h00;
  localparam logic [2:0] MAIN_RESET = 3'h0;
  localparam logic       CODEC_RESET_RESET = 1'b0;
endpackage
